// File: ssp_pkg.sv
package ssp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL1 = 8'hd8;
    localparam logic [7:0] IDX_CTRL2 = 8'hd9;
    localparam logic [7:0] IDX_BAUD  = 8'hda;
    localparam logic [7:0] IDX_FLAGS = 8'hdb;
    localparam logic [7:0] IDX_DATA  = 8'hdd;
    localparam logic [7:0] IDX_FIRST = 8'hd8;
    localparam logic [7:0] IDX_LAST  = 8'hdf;

    localparam logic [7:0] RST_CTRL1 = 8'h04;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_BAUD  = 8'h00;
    localparam logic [7:0] RST_DATA  = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h20;

    localparam logic [7:0] MASK_CTRL2 = 8'h1b;
    localparam logic [7:0] MASK_BAUD  = 8'h77;

    // first_control_register fields
    localparam int B_LINK_IE = 7;
    localparam int B_SYS_EN  = 6;
    localparam int B_TX_IE   = 5;
    localparam int B_MASTER  = 4;
    localparam int B_CLOCK_POLARITY    = 3;
    localparam int B_CLOCK_PHASE    = 2;
    localparam int B_SELECT_OUTPUT_ENABLE    = 1;
    localparam int B_LSBFE   = 0;

    // second_control_register fields
    localparam int B_FAULT_EN = 4;
    localparam int B_BIDIR_OE = 3;
    localparam int B_PIN_CFG  = 0;

    // serial_baud_divider fields, 3 bits each
    localparam int B_PRESEL = 4;
    localparam int B_RATESEL = 0;

    // serial_flags fields
    localparam int B_DONE  = 7;
    localparam int B_EMPTY = 5;
    localparam int B_FAULT = 4;

    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} ssp_state_t;

    typedef struct packed {
        logic ss_n;
        logic sck;
        logic mosi;
        logic miso;
    } ssp_pin_in_t;

    typedef struct packed {
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic sck_o;
        logic sck_oe;
        logic ss_n_o;
        logic ss_oe;
    } ssp_pin_out_t;

endpackage

// File: ssp_top.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module ssp_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire ssp_pkg::ssp_pin_in_t pins_in,
    output ssp_pkg::ssp_pin_out_t     pins_out,
    output logic                      irq
);

    if (ADDR_W < 11) begin
        $error("ssp_top: ADDR_W must be at least 11");
    end

    logic [7:0]             ctrl1_q, ctrl2_q, baud_q, rxbuf_q, txbuf_q, sh_q, rdata_d;
    logic                   txfull_q, transfer_complete_flag_q, mode_fault_flag_q, done_seen_q, empty_seen_q, fault_seen_q;
    logic                   pready_q, pslverr_q, irq_q, out_bit_q, sck_lvl_q, sck_prev_q;
    logic [31:0]            prdata_q;
    ssp_pkg::ssp_pin_in_t   sync1_q, sync2_q;
    ssp_pkg::ssp_pin_out_t  pins_q, pins_d;
    ssp_pkg::ssp_state_t    st_q;
    logic [4:0]             edge_q, edge_num;
    logic [10:0]            div_q, half_m1;
    logic [7:0]             idx, sh_shift, rx_byte;
    logic                   hit, acc, wr, rd, setup;
    logic                   system_enable, master_select, clock_polarity, clock_phase, lsbfe, fault_detect_enable, bidir_output_enable, pin_config_select, select_output_enable;
    logic                   ss_low, slave_sel, din, fault, m_tick, s_edge, edge_ev;
    logic                   sample_ev, shift_ev, done, load, transmit_empty_flag, transfer_complete_flag_clr, mode_fault_flag_clr, rx_take;

    assign pready   = pready_q;
    assign prdata   = prdata_q;
    assign pslverr  = pslverr_q;
    assign pins_out = pins_q;
    assign irq      = irq_q;

    // Bus decode
    assign idx   = paddr[9:2];
    assign hit   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0)
                   && (idx >= ssp_pkg::IDX_FIRST) && (idx <= ssp_pkg::IDX_LAST);
    assign setup = psel && !penable;
    assign acc   = psel && penable && pready_q;
    assign wr    = acc && pwrite && hit;
    assign rd    = acc && !pwrite && hit;

    assign system_enable     = ctrl1_q[ssp_pkg::B_SYS_EN];
    assign master_select    = ctrl1_q[ssp_pkg::B_MASTER];
    assign clock_polarity    = ctrl1_q[ssp_pkg::B_CLOCK_POLARITY];
    assign clock_phase    = ctrl1_q[ssp_pkg::B_CLOCK_PHASE];
    assign lsbfe   = ctrl1_q[ssp_pkg::B_LSBFE];
    assign select_output_enable    = ctrl1_q[ssp_pkg::B_SELECT_OUTPUT_ENABLE];
    assign fault_detect_enable  = ctrl2_q[ssp_pkg::B_FAULT_EN];
    assign bidir_output_enable = ctrl2_q[ssp_pkg::B_BIDIR_OE];
    assign pin_config_select    = ctrl2_q[ssp_pkg::B_PIN_CFG];
    assign transmit_empty_flag   = !txfull_q;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q    <= '1;
            sync2_q    <= '1;
            sck_prev_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q    <= pins_in;
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q.sck;
        end
    end

    assign ss_low    = !sync2_q.ss_n;
    assign slave_sel = system_enable && !master_select && ss_low;
    // Shared pin serves as input in bidirectional configurations
    assign din       = (master_select != pin_config_select) ? sync2_q.miso : sync2_q.mosi;
    // Select used as fault input only when not driven as output
    assign fault     = system_enable && master_select && fault_detect_enable && !select_output_enable && ss_low;

    // Half bit period is (pre+1)*2^sel bus cycles
    assign half_m1 = (11'(baud_q[ssp_pkg::B_PRESEL +: 3]) + 11'h001)
                     << baud_q[ssp_pkg::B_RATESEL +: 3];
    assign m_tick    = master_select && (st_q == ssp_pkg::ST_SHIFT) && (div_q == half_m1 - 11'h001);
    assign s_edge    = slave_sel && (sync2_q.sck != sck_prev_q);
    assign edge_ev   = master_select ? m_tick : s_edge;
    assign edge_num  = edge_q + 5'h01;
    assign sample_ev = edge_ev && (edge_num[0] ^ clock_phase);
    assign shift_ev  = edge_ev && !(edge_num[0] ^ clock_phase);
    assign done      = edge_ev && (edge_num == ssp_pkg::EDGES_PER_BYTE);
    assign sh_shift  = lsbfe ? {din, sh_q[7:1]} : {sh_q[6:0], din};
    assign rx_byte   = sample_ev ? sh_shift : sh_q;

    // Buffer to shifter move, master and slave alike
    assign load = system_enable && txfull_q && (edge_q == 5'h00) && !edge_ev
                  && (master_select ? (st_q == ssp_pkg::ST_IDLE) && !fault : 1'b1);

    assign transfer_complete_flag_clr = rd && (idx == ssp_pkg::IDX_DATA) && done_seen_q;
    assign mode_fault_flag_clr = wr && (idx == ssp_pkg::IDX_CTRL1) && fault_seen_q;
    assign rx_take  = done && (!transfer_complete_flag_q || transfer_complete_flag_clr);

    // APB answer: zero wait states, data captured in setup
    always_comb begin
        rdata_d = 8'h00;
        case (idx)
            ssp_pkg::IDX_CTRL1: rdata_d = ctrl1_q;
            ssp_pkg::IDX_CTRL2: rdata_d = ctrl2_q;
            ssp_pkg::IDX_BAUD:  rdata_d = baud_q;
            ssp_pkg::IDX_FLAGS: begin
                rdata_d[ssp_pkg::B_DONE]  = transfer_complete_flag_q;
                rdata_d[ssp_pkg::B_EMPTY] = transmit_empty_flag;
                rdata_d[ssp_pkg::B_FAULT] = mode_fault_flag_q;
            end
            ssp_pkg::IDX_DATA:  rdata_d = rxbuf_q;
            default:            rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit;
            if (setup) begin
                prdata_q <= (hit && !pwrite) ? {24'h00_0000, rdata_d} : 32'h0000_0000;
            end
        end
    end

    // Control registers; status register ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= ssp_pkg::RST_CTRL1;
            ctrl2_q <= ssp_pkg::RST_CTRL2;
            baud_q  <= ssp_pkg::RST_BAUD;
        end else if (clk_en) begin
            if (wr && idx == ssp_pkg::IDX_CTRL1) begin
                ctrl1_q <= pwdata[7:0];
            end
            if (fault) begin
                ctrl1_q[ssp_pkg::B_MASTER] <= 1'b0;
            end
            if (wr && idx == ssp_pkg::IDX_CTRL2) begin
                ctrl2_q <= pwdata[7:0] & ssp_pkg::MASK_CTRL2;
            end
            if (wr && idx == ssp_pkg::IDX_BAUD) begin
                baud_q <= pwdata[7:0] & ssp_pkg::MASK_BAUD;
            end
        end
    end

    // Clear sequences arm on the status value actually returned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_seen_q  <= 1'b0;
            empty_seen_q <= 1'b0;
            fault_seen_q <= 1'b0;
        end else if (clk_en) begin
            if (rd && idx == ssp_pkg::IDX_FLAGS) begin
                done_seen_q  <= prdata_q[ssp_pkg::B_DONE];
                empty_seen_q <= prdata_q[ssp_pkg::B_EMPTY];
                fault_seen_q <= prdata_q[ssp_pkg::B_FAULT];
            end else begin
                if (transfer_complete_flag_clr) begin
                    done_seen_q <= 1'b0;
                end
                if (wr && idx == ssp_pkg::IDX_DATA) begin
                    empty_seen_q <= 1'b0;
                end
                if (mode_fault_flag_clr) begin
                    fault_seen_q <= 1'b0;
                end
            end
        end
    end

    // Transmit buffer; write refused unless empty was seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_q  <= ssp_pkg::RST_DATA;
            txfull_q <= 1'b0;
        end else if (clk_en) begin
            if (wr && idx == ssp_pkg::IDX_DATA && empty_seen_q) begin
                txbuf_q  <= pwdata[7:0];
                txfull_q <= 1'b1;
            end else if (load) begin
                txfull_q <= 1'b0;
            end
        end
    end

    // Status flags; a set beats a simultaneous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_complete_flag_q  <= ssp_pkg::RST_FLAGS[ssp_pkg::B_DONE];
            mode_fault_flag_q  <= ssp_pkg::RST_FLAGS[ssp_pkg::B_FAULT];
            rxbuf_q <= ssp_pkg::RST_DATA;
        end else if (clk_en) begin
            transfer_complete_flag_q <= done || (transfer_complete_flag_q && !transfer_complete_flag_clr);
            mode_fault_flag_q <= fault || (mode_fault_flag_q && !mode_fault_flag_clr);
            if (rx_take) begin
                rxbuf_q <= rx_byte;
            end
        end
    end

    // Shift engine: divider runs only while a master shifts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= ssp_pkg::ST_IDLE;
            div_q     <= 11'h000;
            edge_q    <= 5'h00;
            sck_lvl_q <= 1'b0;
        end else if (clk_en) begin
            case (st_q)
                ssp_pkg::ST_IDLE: begin
                    if (load && master_select) begin
                        st_q <= ssp_pkg::ST_SHIFT;
                    end
                end
                ssp_pkg::ST_SHIFT: begin
                    if (done || fault || !master_select || !system_enable) begin
                        st_q <= ssp_pkg::ST_IDLE;
                    end
                end
                default: st_q <= ssp_pkg::ST_IDLE;
            endcase
            div_q <= (m_tick || st_q != ssp_pkg::ST_SHIFT || !master_select) ? 11'h000 : div_q + 11'h001;
            if (done || (master_select ? (st_q == ssp_pkg::ST_IDLE || fault) : !slave_sel)) begin
                edge_q <= 5'h00;
            end else if (edge_ev) begin
                edge_q <= edge_num;
            end
            // Idle level follows polarity; toggles on every divider tick
            sck_lvl_q <= (st_q == ssp_pkg::ST_SHIFT && master_select) ? sck_lvl_q ^ m_tick : clock_polarity;
        end
    end

    // Shifter and outgoing bit; shifter content undefined-free after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q      <= 8'h00;
            out_bit_q <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                sh_q <= txbuf_q;
            end else if (sample_ev) begin
                sh_q <= sh_shift;
            end
            if (edge_q == 5'h00 && !edge_ev) begin
                out_bit_q <= load ? (lsbfe ? txbuf_q[0] : txbuf_q[7]) : (lsbfe ? sh_q[0] : sh_q[7]);
            end else if (shift_ev) begin
                out_bit_q <= lsbfe ? sh_q[0] : sh_q[7];
            end
        end
    end

    // Pin drivers, gated off at once on a fault
    always_comb begin
        pins_d.mosi_o  = out_bit_q;
        pins_d.miso_o  = out_bit_q;
        pins_d.sck_o   = master_select ? sck_lvl_q : clock_polarity;
        pins_d.ss_n_o  = (st_q != ssp_pkg::ST_SHIFT);
        pins_d.mosi_oe = system_enable && master_select && !fault && (pin_config_select ? bidir_output_enable : 1'b1);
        pins_d.miso_oe = system_enable && !master_select && ss_low && (pin_config_select ? bidir_output_enable : 1'b1);
        pins_d.sck_oe  = system_enable && master_select && !fault;
        pins_d.ss_oe   = system_enable && fault_detect_enable && select_output_enable && master_select;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= '0;
            irq_q  <= 1'b0;
        end else if (clk_en) begin
            pins_q <= pins_d;
            irq_q  <= system_enable && ((ctrl1_q[ssp_pkg::B_LINK_IE] && (transfer_complete_flag_q || mode_fault_flag_q))
                              || (ctrl1_q[ssp_pkg::B_TX_IE] && transmit_empty_flag));
        end
    end

    a_slave_bidir_oe: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && system_enable && pin_config_select && !master_select |=> pins_q.miso_oe == $past(bidir_output_enable && ss_low))
        else $error("bidir slave output enable wrong");

    a_master_bidir_oe: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && system_enable && pin_config_select && master_select && !fault |=> pins_q.mosi_oe == $past(bidir_output_enable))
        else $error("bidir master output enable wrong");

    a_clock_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pins_d.sck_oe |-> master_select && system_enable)
        else $error("clock pin driven outside master mode");

    a_select_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> pins_q.ss_oe == $past(system_enable && fault_detect_enable && select_output_enable && master_select))
        else $error("select pin direction wrong");

    a_divider_tick: assert property (@(posedge pclk) disable iff (!presetn)
        m_tick && clk_en |-> div_q + 11'h001 == half_m1)
        else $error("divider tick at wrong count");

    a_baud_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (baud_q & ~ssp_pkg::MASK_BAUD) == 8'h00)
        else $error("unused baud bits not zero");

    a_done_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && done && !transfer_complete_flag_q |=> transfer_complete_flag_q && rxbuf_q == $past(rx_byte))
        else $error("transfer complete not flagged");

    a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && wr && idx == ssp_pkg::IDX_DATA && !empty_seen_q |=> $stable(txbuf_q))
        else $error("unarmed data write accepted");

    a_idle_load: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && system_enable && master_select && txfull_q && st_q == ssp_pkg::ST_IDLE && edge_q == 5'h00 && !fault
        |=> !txfull_q && st_q == ssp_pkg::ST_SHIFT)
        else $error("idle byte not moved to shifter");

    a_fault_effects: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && fault |=> mode_fault_flag_q && !master_select && !pins_q.sck_oe && !pins_q.mosi_oe)
        else $error("mode fault effects missing");

    a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && done && transfer_complete_flag_q && !transfer_complete_flag_clr |=> $stable(rxbuf_q))
        else $error("unserviced byte overwritten");

    a_irq_request: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && system_enable && ctrl1_q[ssp_pkg::B_TX_IE] && transmit_empty_flag |=> irq_q)
        else $error("transmit empty interrupt missing");

endmodule

// File: ssp_far_slave.sv
`timescale 1ns/1ps
module ssp_far_slave (
    input  wire logic       sck,
    input  wire logic       pol,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] nxt,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] shr;
    logic       lat;
    logic       last;
    logic       ck;
    int         cnt;
    initial begin
        shr = 8'h00;
        lat = 1'b0;
        last = 1'b0;
        cnt = 0;
        got = 8'h00;
    end
    always @(negedge sel_n) begin
        shr = nxt;
        cnt = 0;
    end
    assign ck = sck ^ pol;
    // Phase 0 only: leading edge latches, trailing edge shifts
    always @(posedge ck) if (!sel_n) begin
        lat = mosi;
        cnt++;
    end
    // Last shift may meet the select release in the same step
    always @(negedge ck) if (!sel_n || cnt == 8) begin
        shr = {shr[6:0], lat};
        if (cnt == 8) begin
            got = shr;
            shr = nxt;
            cnt = 0;
        end
    end
    always @* if (!sel_n) last = shr[7];
    // Released line flips so a stale bit can never pass as data
    assign miso = sel_n ? ~last : shr[7];
endmodule

// File: spi_master_slave_port_tb_top.sv
`timescale 1ns/1ps
module spi_master_slave_port_tb_top;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  irq;
    logic                  ss_in_n;
    logic                  far_miso;
    logic [7:0]            far_nxt;
    logic [7:0]            far_got;
    logic                  far_pol;
    logic [7:0]            a_b;
    logic [7:0]            b_b;
    logic [7:0]            s1;
    logic [7:0]            s2;
    logic [31:0]           rnd;
    logic [32:0]           exp_q[$];
    ssp_pkg::ssp_pin_in_t  pin_i;
    ssp_pkg::ssp_pin_out_t pin_o;
    int                    n_mismatch;
    int                    comparisons;
    assign pin_i.ss_n = pin_o.ss_oe ? pin_o.ss_n_o : ss_in_n;
    assign pin_i.sck = pin_o.sck_oe ? pin_o.sck_o : 1'b0;
    assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : 1'b1;
    assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : far_miso;
    ssp_top i_ssp_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pins_in(pin_i), .pins_out(pin_o), .irq(irq));
    ssp_far_slave i_ssp_far_slave (.sck(pin_i.sck), .pol(far_pol), .mosi(pin_i.mosi), .sel_n(pin_i.ss_n),
        .nxt(far_nxt), .miso(far_miso), .got(far_got));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
        comparisons++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic limit_check(input logic out_of_time);
        if (out_of_time) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_mismatch++;
            conclude();
        end
        r = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] r;
        apb(1'b1, ad(i), d, r);
    endtask
    // Expected answer is queued first; the watcher pairs it with the read
    task automatic rx(input logic [11:0] a, input logic er, input logic [7:0] b);
        logic [7:0] r;
        exp_q.push_back({er, 24'h0, b});
        apb(1'b0, a, 8'h00, r);
    endtask
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            chk("read", {pslverr, prdata}, exp_q.pop_front());
    end
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wait_done();
        logic [7:0] r;
        int n;
        n = 0;
        r = 8'h00;
        while (r[7] !== 1'b1 && n < 400) begin
            apb(1'b0, ad(ssp_pkg::IDX_FLAGS), 8'h00, r);
            n++;
        end
        if (r[7] !== 1'b1) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic half_period(input int h);
        int n;
        n = 0;
        while (pin_o.sck_o !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        limit_check(n >= 300);
        n = 0;
        while (pin_o.sck_o === 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        limit_check(n >= 300);
        chk("half period", 33'(n), 33'(h));
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end
    initial begin
        int n;
        {presetn, psel, penable, pwrite, paddr, pwdata, far_nxt, far_pol} = '0;
        ss_in_n = 1'b1;
        rnd = 32'h6fd5;
        n_mismatch = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(ssp_pkg::IDX_DATA, 8'h5a);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, ssp_pkg::RST_FLAGS);
        rx(ad(ssp_pkg::IDX_CTRL1), 1'b0, ssp_pkg::RST_CTRL1);
        rx(ad(ssp_pkg::IDX_CTRL2), 1'b0, ssp_pkg::RST_CTRL2);
        rx(ad(ssp_pkg::IDX_BAUD), 1'b0, ssp_pkg::RST_BAUD);
        rx(ad(ssp_pkg::IDX_DATA), 1'b0, ssp_pkg::RST_DATA);
        rx(ad(8'hdc), 1'b0, 8'h00);
        rx(12'h004, 1'b1, 8'h00);
        rx(12'h361, 1'b1, 8'h00);
        wr(ssp_pkg::IDX_BAUD, 8'hff);
        rx(ad(ssp_pkg::IDX_BAUD), 1'b0, ssp_pkg::MASK_BAUD);
        wr(ssp_pkg::IDX_FLAGS, 8'h00);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        // Divider set while idle, never 2 or 4
        wr(ssp_pkg::IDX_BAUD, 8'h13);
        wr(ssp_pkg::IDX_CTRL2, 8'h10);
        wr(ssp_pkg::IDX_CTRL1, 8'h52);
        idle(4);
        chk("oe", {29'h0, pin_o.mosi_oe, pin_o.miso_oe, pin_o.sck_oe, pin_o.ss_oe}, 33'h0b);
        {s1, a_b} = rnd[15:0];
        rnd = lfsr(rnd);
        {s2, b_b} = rnd[15:0];
        far_nxt <= s1;
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        wr(ssp_pkg::IDX_DATA, a_b);
        idle(1);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        wr(ssp_pkg::IDX_DATA, b_b);
        far_nxt <= s2;
        half_period(16);
        wait_done();
        chk("far byte", {25'h0, far_got}, {25'h0, a_b});
        n = 0;
        while (far_got !== b_b && n < 600) begin
            @(posedge pclk);
            n++;
        end
        limit_check(n >= 600);
        idle(8);
        chk("second byte", {25'h0, far_got}, {25'h0, b_b});
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'ha0);
        rx(ad(ssp_pkg::IDX_DATA), 1'b0, s1);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        // Inverted clock: idle level high, same data format
        far_pol <= 1'b1;
        wr(ssp_pkg::IDX_CTRL1, 8'h5a);
        rnd = lfsr(rnd);
        {s1, a_b} = rnd[15:0];
        far_nxt <= s1;
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        wr(ssp_pkg::IDX_DATA, a_b);
        wait_done();
        chk("inverted clock byte", {25'h0, far_got}, {25'h0, a_b});
        rx(ad(ssp_pkg::IDX_DATA), 1'b0, s1);
        far_pol <= 1'b0;
        wr(ssp_pkg::IDX_CTRL1, 8'h50);
        ss_in_n <= 1'b0;
        idle(6);
        chk("fault oe", {31'h0, pin_o.sck_oe, pin_o.mosi_oe}, 33'h0);
        rx(ad(ssp_pkg::IDX_CTRL1), 1'b0, 8'h40);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h30);
        ss_in_n <= 1'b1;
        wr(ssp_pkg::IDX_CTRL1, 8'h60);
        idle(2);
        chk("irq", {32'h0, irq}, 33'h1);
        rx(ad(ssp_pkg::IDX_FLAGS), 1'b0, 8'h20);
        wr(ssp_pkg::IDX_CTRL1, 8'h40);
        wr(ssp_pkg::IDX_CTRL2, 8'h09);
        chk("irq", {32'h0, irq}, 33'h0);
        ss_in_n <= 1'b0;
        idle(4);
        chk("bidir slave", {31'h0, pin_o.miso_oe, pin_o.sck_oe}, 33'h2);
        ss_in_n <= 1'b1;
        idle(4);
        chk("unselected", {32'h0, pin_o.miso_oe}, 33'h0);
        wr(ssp_pkg::IDX_CTRL1, 8'h50);
        idle(4);
        chk("bidir master", {29'h0, pin_o.mosi_oe, pin_o.sck_oe, pin_o.miso_oe, pin_o.ss_oe}, 33'hc);
        wr(ssp_pkg::IDX_CTRL1, 8'h10);
        idle(4);
        chk("off", {29'h0, pin_o.mosi_oe, pin_o.sck_oe, pin_o.miso_oe, pin_o.ss_oe}, 33'h0);
        conclude();
    end
endmodule
